//--- rtl/letterbox_pkg.sv
// Register map, field layout, reset values and line constants of the letterbox detector
package letterbox_pkg;
  // Register addresses on the serial register port
  localparam logic [7:0] TOP_COUNT_ADDR = 8'h9b;
  localparam logic [7:0] MID_COUNT_ADDR = 8'h9c;
  localparam logic [7:0] BOTTOM_COUNT_ADDR = 8'h9d;
  localparam logic [7:0] THRESHOLD_ADDR = 8'hdc;
  localparam logic [7:0] WINDOW_ADDR = 8'hdd;
  // Field positions in the window register
  localparam int START_LSB = 4;
  localparam int END_LSB = 0;
  // Reset values
  localparam logic [4:0] THRESHOLD_RESET = 5'h0c;
  localparam logic [3:0] START_RESET = 4'h4;
  localparam logic [3:0] END_RESET = 4'hd;
  localparam logic [4:0] THRESHOLD_MAX = 5'h10;
  // Line numbering: code 4 maps to line 23, code 13 to line 262
  localparam logic [9:0] START_LINE_BASE = 10'h013;
  localparam logic [9:0] END_LINE_BASE = 10'h0f9;
  localparam logic [9:0] FIELD_MID_LINE = 10'h08e;
  // Run lengths needed before a count is reported
  localparam logic [7:0] MIN_BLOCK_LINES = 8'h06;
  localparam logic [7:0] MIN_BAND_LINES = 8'h02;
endpackage

//--- rtl/letterbox_line_detector.sv
// Letterbox detector: black line classification, run counting and count registers
// Contract
// - Sum active luminance per line, compare with threshold at line end.
// - Five-bit threshold setting, reset value selects the default threshold.
// - Codes above default up to maximum raise the threshold.
// - Codes below default lower the threshold.
// - Top count reported only after six consecutive black lines; value is lines found.
// - Top window start programmable per line through a four-bit setting.
// - Top window closes at the middle of the field.
// - Default start code aligns with active video; each step moves one line.
// - Bottom count reported only after six continuous black lines; value is lines found.
// - Bottom window opens mid field; closing line set by four-bit setting.
// - Default end code ends at last active line; lower codes end earlier.
// - Mid count reported after two black lines, a band, then bottom block.
// - Without a subtitle band the mid count equals the bottom count.
// - Counts become visible two fields after the measured field.
// - Top, mid and bottom counts are eight-bit read-only at consecutive addresses.
// - Start setting in upper nibble, end setting in lower nibble, one register.
`timescale 1ns/1ns
`default_nettype none
module letterbox_line_detector #(
  parameter int SUM_W = 20,
  parameter int THRESHOLD_UNIT = 1024
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Luminance stream and timing
  input wire logic [7:0] luma_i,
  input wire logic luma_valid_i,
  input wire logic line_end_i,
  input wire logic field_start_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  // Saturating increment of an eight-bit run counter
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // Settings
  logic [4:0] thr_code_q;
  logic [3:0] start_code_q;
  logic [3:0] end_code_q;
  // Line accumulation
  logic [SUM_W-1:0] acc_q;
  logic [9:0] line_q;
  // Top run state
  logic [7:0] top_run_q;
  logic top_done_q;
  // Bottom and band state
  logic [7:0] bot_run_q;
  logic [7:0] span_q;
  logic band_q;
  // Result pipeline
  logic [7:0] stage_top_q, stage_mid_q, stage_bot_q;
  logic [7:0] vis_top_q, vis_mid_q, vis_bot_q;
  logic [7:0] rdata_q;
  // History of field results for the delay check
  logic [7:0] hist_top_q, hist_mid_q, hist_bot_q;

  // Threshold from code, clamped at the documented maximum
  wire [4:0] thr_clamped_w = (thr_code_q > letterbox_pkg::THRESHOLD_MAX) ?
                             letterbox_pkg::THRESHOLD_MAX : thr_code_q;
  wire [SUM_W-1:0] thresh_w = SUM_W'(({27'h0, thr_clamped_w} + 32'h1) * THRESHOLD_UNIT);
  wire [SUM_W-1:0] default_thresh_w =
    SUM_W'(({27'h0, letterbox_pkg::THRESHOLD_RESET} + 32'h1) * THRESHOLD_UNIT);

  // Line total and black decision
  wire [SUM_W-1:0] total_w = acc_q + (luma_valid_i ? SUM_W'(luma_i) : '0);
  wire black_w = total_w < thresh_w;
  wire line_done_w = line_end_i && !field_start_i;

  // Detection windows in field line numbers
  wire [9:0] start_line_w = letterbox_pkg::START_LINE_BASE + 10'(start_code_q);
  wire [9:0] end_line_w = letterbox_pkg::END_LINE_BASE + 10'(end_code_q);
  wire in_top_w = (line_q >= start_line_w) && (line_q < letterbox_pkg::FIELD_MID_LINE);
  wire in_bot_w = (line_q >= letterbox_pkg::FIELD_MID_LINE) && (line_q <= end_line_w);

  // Field results, zero unless the block is long enough
  wire [7:0] top_res_w = (top_run_q >= letterbox_pkg::MIN_BLOCK_LINES) ? top_run_q : 8'h00;
  wire [7:0] bot_res_w = (bot_run_q >= letterbox_pkg::MIN_BLOCK_LINES) ? bot_run_q : 8'h00;
  wire [7:0] mid_res_w = (band_q && bot_res_w != 8'h00) ? span_q : bot_res_w;

  // Register decode
  wire wr_thr_w = reg_wr_i && (reg_addr_i == letterbox_pkg::THRESHOLD_ADDR);
  wire wr_win_w = reg_wr_i && (reg_addr_i == letterbox_pkg::WINDOW_ADDR);
  wire [7:0] rd_mux_w =
    (reg_addr_i == letterbox_pkg::TOP_COUNT_ADDR) ? vis_top_q :
    (reg_addr_i == letterbox_pkg::MID_COUNT_ADDR) ? vis_mid_q :
    (reg_addr_i == letterbox_pkg::BOTTOM_COUNT_ADDR) ? vis_bot_q :
    (reg_addr_i == letterbox_pkg::THRESHOLD_ADDR) ? {3'h0, thr_code_q} :
    (reg_addr_i == letterbox_pkg::WINDOW_ADDR) ? {start_code_q, end_code_q} : 8'h00;

  // Software settings
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      thr_code_q <= letterbox_pkg::THRESHOLD_RESET;
      start_code_q <= letterbox_pkg::START_RESET;
      end_code_q <= letterbox_pkg::END_RESET;
    end else begin
      if (wr_thr_w) begin
        thr_code_q <= reg_wdata_i[4:0];
      end
      if (wr_win_w) begin
        start_code_q <= reg_wdata_i[letterbox_pkg::START_LSB +: 4];
        end_code_q <= reg_wdata_i[letterbox_pkg::END_LSB +: 4];
      end
    end
  end

  // Read data, held until the next read
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux_w;
    end
  end
  assign reg_rdata_o = rdata_q;

  // Luminance accumulation and line counting
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= '0;
      line_q <= 10'h001;
    end else if (field_start_i) begin
      acc_q <= '0;
      line_q <= 10'h001;
    end else if (line_end_i) begin
      acc_q <= '0;
      line_q <= (line_q == 10'h3ff) ? line_q : line_q + 10'h001;
    end else if (luma_valid_i) begin
      acc_q <= total_w;
    end
  end

  // Top run: counts black lines from window start, stops at first non-black
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      top_run_q <= 8'h00;
      top_done_q <= 1'b0;
    end else if (field_start_i) begin
      top_run_q <= 8'h00;
      top_done_q <= 1'b0;
    end else if (line_done_w && in_top_w && !top_done_q) begin
      if (black_w) begin
        top_run_q <= sat_inc(top_run_q);
      end else begin
        top_done_q <= 1'b1;
      end
    end
  end

  // Bottom run ends at window close; after a band the span also counts lit lines
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bot_run_q <= 8'h00;
      span_q <= 8'h00;
      band_q <= 1'b0;
    end else if (field_start_i) begin
      bot_run_q <= 8'h00;
      span_q <= 8'h00;
      band_q <= 1'b0;
    end else if (line_done_w && in_bot_w) begin
      if (black_w) begin
        bot_run_q <= sat_inc(bot_run_q);
        span_q <= sat_inc(span_q);
      end else begin
        bot_run_q <= 8'h00;
        if (bot_run_q >= letterbox_pkg::MIN_BAND_LINES) begin
          band_q <= 1'b1;
          span_q <= sat_inc(bot_run_q);
        end else begin
          span_q <= band_q ? sat_inc(span_q) : 8'h00;
        end
      end
    end
  end

  // Two-stage result pipeline, all three counts move on the same edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage_top_q <= 8'h00;
      stage_mid_q <= 8'h00;
      stage_bot_q <= 8'h00;
      vis_top_q <= 8'h00;
      vis_mid_q <= 8'h00;
      vis_bot_q <= 8'h00;
    end else if (field_start_i) begin
      stage_top_q <= top_res_w;
      stage_mid_q <= mid_res_w;
      stage_bot_q <= bot_res_w;
      vis_top_q <= stage_top_q;
      vis_mid_q <= stage_mid_q;
      vis_bot_q <= stage_bot_q;
    end
  end

  // Result of each field, kept one field start for the delay check
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hist_top_q <= 8'h00;
      hist_mid_q <= 8'h00;
      hist_bot_q <= 8'h00;
    end else if (field_start_i) begin
      hist_top_q <= top_res_w;
      hist_mid_q <= mid_res_w;
      hist_bot_q <= bot_res_w;
    end
  end

  // Checks on the detector behaviour
  a_top_min_run: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    vis_top_q == 8'h00 || vis_top_q >= 8'h06)
    else $error("top count below six lines");
  a_bot_min_run: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    vis_bot_q == 8'h00 || vis_bot_q >= 8'h06)
    else $error("bottom count below six lines");
  a_mid_no_band: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && !band_q |=> stage_mid_q == stage_bot_q)
    else $error("mid count differs without band");
  a_mid_covers_bot: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    vis_mid_q >= vis_bot_q)
    else $error("mid count below bottom count");
  a_counts_together: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (vis_top_q != $past(vis_top_q) || vis_mid_q != $past(vis_mid_q) ||
     vis_bot_q != $past(vis_bot_q)) |-> $past(field_start_i))
    else $error("count changed outside field start");
  // Each visible count is the result latched at the previous field start
  a_two_field_delay: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i |=> vis_top_q == $past(hist_top_q))
    else $error("top count not visible two fields later");
  a_two_field_mid: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i |=> vis_mid_q == $past(hist_mid_q))
    else $error("mid count not visible two fields later");
  a_two_field_bot: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i |=> vis_bot_q == $past(hist_bot_q))
    else $error("bottom count not visible two fields later");
  a_thresh_raise: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    thr_code_q > letterbox_pkg::THRESHOLD_RESET |-> thresh_w > default_thresh_w)
    else $error("higher code did not raise threshold");
  a_thresh_lower: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    thr_code_q < letterbox_pkg::THRESHOLD_RESET |-> thresh_w < default_thresh_w)
    else $error("lower code did not lower threshold");
  a_top_freeze: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !field_start_i && (!in_top_w || top_done_q) |=> top_run_q == $past(top_run_q))
    else $error("top run moved outside window");
  a_window_write: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    wr_win_w |=> start_code_q == $past(reg_wdata_i[7:4]) && end_code_q == $past(reg_wdata_i[3:0]))
    else $error("window setting not taken");
  // Threshold write keeps only the five code bits
  a_thr_write: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    wr_thr_w |=>
    thr_code_q == $past(reg_wdata_i[4:0]))
    else $error("threshold setting not taken");
  // Read data must not wander between reads
  a_rdata_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !reg_rd_i |=>
    reg_rdata_o == $past(reg_rdata_o))
    else $error("read data changed without a read");
  // Top count register is read-only
  a_count_readonly: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    reg_wr_i && reg_addr_i == letterbox_pkg::TOP_COUNT_ADDR && !field_start_i |=>
    vis_top_q == $past(vis_top_q))
    else $error("write reached a count register");
  // Once the top run has ended it stays ended for the field
  a_top_stops: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    top_done_q && !field_start_i |=>
    top_done_q)
    else $error("top run restarted within field");
  // A field start restarts line numbering and the sum
  a_line_restart: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i |=>
    line_q == 10'h001 && acc_q == '0)
    else $error("line count not restarted");
  // Outside the bottom window the run must hold
  a_bot_window_end: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    line_done_w && !in_bot_w && !field_start_i |=>
    bot_run_q == $past(bot_run_q))
    else $error("bottom run moved outside window");
  // A lit line inside the top window ends the top run
  a_top_nonblack_ends: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    line_done_w && in_top_w && !top_done_q && !black_w |=>
    top_done_q)
    else $error("lit line did not end top run");
  // A band once seen is kept until the field ends
  a_band_sticky: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    band_q && !field_start_i |=>
    band_q)
    else $error("band flag lost within field");
  // A lit line in the bottom window clears the bottom run
  a_bot_clear_lit: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    line_done_w && in_bot_w && !black_w |=>
    bot_run_q == 8'h00)
    else $error("lit line did not clear bottom run");
  // Each black line in the top window adds exactly one
  a_top_run_step: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    line_done_w && in_top_w && !top_done_q && black_w && top_run_q != 8'hff |=>
    top_run_q == $past(top_run_q) + 8'h01)
    else $error("top run did not step");
  // The sum restarts after every line end
  a_acc_line_clear: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    line_end_i |=>
    acc_q == '0)
    else $error("line sum not cleared");
  // With a band the mid result is the whole span
  a_mid_span: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && band_q && bot_res_w != 8'h00 |=>
    stage_mid_q == $past(span_q))
    else $error("mid count is not the span");
  // A short top run reports zero
  a_zero_short_top: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && top_run_q < letterbox_pkg::MIN_BLOCK_LINES |=>
    stage_top_q == 8'h00)
    else $error("short top run reported");
  // A short bottom run reports zero
  a_zero_short_bot: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && bot_run_q < letterbox_pkg::MIN_BLOCK_LINES |=>
    stage_bot_q == 8'h00)
    else $error("short bottom run reported");
  // Window register reads back both nibbles in place
  a_window_read: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    reg_rd_i && reg_addr_i == letterbox_pkg::WINDOW_ADDR |=>
    reg_rdata_o == {$past(start_code_q), $past(end_code_q)})
    else $error("window register read wrong");

  // Main scenarios
  c_top_found: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && top_res_w != 8'h00);
  c_band_found: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && band_q && bot_res_w != 8'h00);
  c_count_visible: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    vis_bot_q != 8'h00);
  c_threshold_max: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && thr_code_q == letterbox_pkg::THRESHOLD_MAX);
  c_window_moved: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    field_start_i && start_code_q != letterbox_pkg::START_RESET);

endmodule
`default_nettype wire

//--- test/luma_source.sv
// Luminance source model: fields of 262 lines, each black or lit
`timescale 1ns/1ns
`default_nettype none
module luma_source (
  // Clock and pattern
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic [9:0] top_end_i,
  input wire logic [9:0] bot_start_i,
  input wire logic [9:0] band_lo_i,
  input wire logic [9:0] band_hi_i,
  input wire logic [7:0] level_i,
  // Stream
  output logic [7:0] luma_o,
  output logic luma_valid_o,
  output logic line_end_o,
  output logic field_start_o
);
  logic [9:0] te, bs, bl, bh;
  logic dark;
  // Pattern latched per field; idle luma toggles so stale data never looks valid
  initial begin
    luma_o = 8'h5a;
    luma_valid_o = 1'b0;
    line_end_o = 1'b0;
    field_start_o = 1'b0;
    forever begin
      @(negedge clock_i);
      if (run_i) begin
        {te, bs, bl, bh} = {top_end_i, bot_start_i, band_lo_i, band_hi_i};
        field_start_o = 1'b1;
        @(negedge clock_i);
        field_start_o = 1'b0;
        for (int l = 1; l <= 262; l++) begin
          dark = (l >= 23 && l <= te) || (l >= bs && !(l >= bl && l <= bh));
          for (int s = 0; s < 10; s++) begin
            luma_valid_o = s < 8;
            luma_o = s < 8 ? (dark ? 8'h00 : level_i) : ~luma_o;
            line_end_o = s == 7;
            @(negedge clock_i);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- test/letterbox_line_detector_bench.sv
// Self-checking bench of the letterbox detector
`timescale 1ns/1ns
`default_nettype none
module letterbox_line_detector_bench;
  typedef struct packed {
    logic [9:0] te, bs, bl, bh;
    logic [7:0] lv;
    logic [4:0] th;
    logic [7:0] win, top, mid, bot;
  } row_s;
  row_s rows [7];
  row_s prev;
  logic clock_i, arst_n_i, luma_valid_i, line_end_i, field_start_i, reg_wr_i, reg_rd_i, run;
  logic [7:0] luma_i, reg_addr_i, reg_wdata_i, reg_rdata_o, lv;
  logic [9:0] te, bs, bl, bh;
  int err_total, checks;
  // Small threshold unit keeps lines short
  letterbox_line_detector #(.THRESHOLD_UNIT(128)) dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .luma_i(luma_i), .luma_valid_i(luma_valid_i), .line_end_i(line_end_i),
    .field_start_i(field_start_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  luma_source src (.clock_i(clock_i), .run_i(run), .top_end_i(te), .bot_start_i(bs),
    .band_lo_i(bl), .band_hi_i(bh), .level_i(lv), .luma_o(luma_i),
    .luma_valid_o(luma_valid_i), .line_end_o(line_end_i), .field_start_o(field_start_i));
  // 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    @(negedge clock_i);
    checks++;
    if (reg_rdata_o !== exp) begin
      err_total++;
      $display("MISMATCH %0t: addr %h got %h want %h", $time, a, reg_rdata_o, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic counts(input row_s r);
    rd(8'h9b, r.top);
    rd(8'h9c, r.mid);
    rd(8'h9d, r.bot);
  endtask
  // Bounded wait for the next field start
  task automatic next_field;
    int n;
    n = 0;
    while (field_start_i !== 1'b1 && n < 4000) begin
      @(posedge clock_i);
      n++;
    end
    if (n == 4000) begin
      err_total++;
      $display("MISMATCH %0t: no field start", $time);
      results();
    end else begin
      @(negedge clock_i);
    end
  endtask
  initial begin
    {arst_n_i, reg_wr_i, reg_rd_i, run, reg_addr_i, reg_wdata_i} = '0;
    {te, bs, bl, bh, lv, prev} = '0;
    rows[0] = {10'h034, 10'h0e9, 10'h001, 10'h000, 8'hff, 5'h0c, 8'h4d, 8'h1e, 8'h1e, 8'h1e};
    rows[1] = {10'h01b, 10'h102, 10'h001, 10'h000, 8'hff, 5'h0c, 8'h4d, 8'h00, 8'h00, 8'h00};
    rows[2] = {10'h01c, 10'h101, 10'h001, 10'h000, 8'hff, 5'h0c, 8'h4d, 8'h06, 8'h06, 8'h06};
    rows[3] = {10'h01c, 10'h0dc, 10'h0e6, 10'h0eb, 8'hff, 5'h0c, 8'h4d, 8'h06, 8'h2b, 8'h1b};
    rows[4] = {10'h034, 10'h0e9, 10'h001, 10'h000, 8'hff, 5'h10, 8'h4d, 8'h77, 8'h79, 8'h79};
    rows[5] = {10'h034, 10'h0e9, 10'h001, 10'h000, 8'h10, 5'h00, 8'h4d, 8'h1e, 8'h1e, 8'h1e};
    rows[6] = {10'h034, 10'h0e9, 10'h001, 10'h000, 8'hff, 5'h0c, 8'h5c, 8'h1d, 8'h1d, 8'h1d};
    repeat (16) @(negedge clock_i);
    arst_n_i = 1'b1;
    rd(8'hdc, 8'h0c);
    rd(8'hdd, 8'h4d);
    counts(prev);
    rd(8'h00, 8'h00);
    wr(8'h9b, 8'hff);
    rd(8'h9b, 8'h00);
    wr(8'hdc, 8'hff);
    rd(8'hdc, 8'h1f);
    wr(8'hdd, 8'ha5);
    rd(8'hdd, 8'ha5);
    // Each row: program, stream, old counts after one field, new after three
    foreach (rows[i]) begin
      wr(8'hdc, {3'h0, rows[i].th});
      wr(8'hdd, rows[i].win);
      {te, bs, bl, bh, lv} = {rows[i].te, rows[i].bs, rows[i].bl, rows[i].bh, rows[i].lv};
      @(negedge clock_i);
      run = 1'b1;
      next_field();
      counts(prev);
      next_field();
      next_field();
      counts(rows[i]);
      prev = rows[i];
    end
    // Reset in mid-stream: settings and counts return to defaults
    arst_n_i = 1'b0;
    repeat (16) @(negedge clock_i);
    arst_n_i = 1'b1;
    rd(8'hdc, 8'h0c);
    rd(8'hdd, 8'h4d);
    prev = '0;
    counts(prev);
    results();
  end
endmodule
`default_nettype wire
